// >>> hdl/rmp_pkg.sv
// Behaviour
// - Bus error high and data bit 1 low at reset selects 16-bit bus.
// - Emulation chip select enabled only when data bits 10 and 1 sampled low.
// - 16-bit mode: grant/module select pin held high if bits 13,10,1 low.
// - Bus error high and data bit 1 high at reset selects 8-bit bus.
// - 8-bit: low byte is port H, high byte data, no ports A,B,G.
// - 8-bit: upper pins chip selects, low address pins driven, no emulation.
// - Data bit 8 low moves strobes, acks, autovector, size to port E.
// - Data bit 9 low moves interrupt requests and clock-mode pin to port F.
// - 8-bit: boot select 8-bit, fixed selects, codes and grants regardless.
// - Bus error low at reset selects single-chip; tied low is valid.
// - Single-chip: data lines ports G,H, address 18..3 ports A,B.
// - Single-chip: option pins ignored, all I/O ports selected.
// - Single-chip: low address pins float, disable bit set, clear enables.
// - Single-chip: codes and chip-select pins are port C, top pin unused.
// - Clock-mode pin high selects synthesizer, low selects external clock.
package rmp_pkg;
  // bus configuration codes
  typedef enum logic [1:0] {
    RMP_BUS_SINGLE = 2'h0,
    RMP_BUS_8BIT   = 2'h1,
    RMP_BUS_16BIT  = 2'h2
  } rmp_bus_t;

  // data line positions used as option selects
  localparam int RMP_D_BOOT16 = 0;
  localparam int RMP_D_WIDTH  = 1;
  localparam int RMP_D_CS0    = 2;
  localparam int RMP_D_CSLO   = 3;
  localparam int RMP_D_PORTE  = 8;
  localparam int RMP_D_PORTF  = 9;
  localparam int RMP_D_EMUL   = 10;
  localparam int RMP_D_MODCS  = 13;
  localparam int RMP_NUM_HICS = 5;

  // first bus cycle delay after reset release, in output-clock cycles
  localparam int RMP_FIRST_CYCLE_CLKS = 10;
  localparam logic [3:0] RMP_FIRST_CYCLE_CNT = 4'(RMP_FIRST_CYCLE_CLKS);
endpackage

// >>> hdl/rmp_sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of pin levels
module rmp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // a bundle needs at least one line
  if (W < 1) begin : g_bad_width
    $error("rmp_sync2 width must be positive");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rmp_sync_st_t;

  rmp_sync_st_t st_ff;
  rmp_sync_st_t nxt_st;

  // shift the pin levels through two stages
  always_comb begin
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end

  // pull-ups make idle pins read high
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.s2;
endmodule

// >>> hdl/rmp_reset_mode.sv
`timescale 1ns/1ps
// reset-time pin configuration: samples mode pins while reset is held
module rmp_reset_mode (
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 sys_reset_n_i,
  input  wire logic [15:0]          data_pins_i,
  input  wire logic                 bus_error_input_i,
  input  wire logic                 clock_source_select_pin_i,
  input  wire logic                 low_address_disable_clr_i,
  output rmp_pkg::rmp_bus_t         bus_mode_o,
  output logic                      boot_cs_16bit_o,
  output logic                      port_h_sel_o,
  output logic                      port_g_sel_o,
  output logic                      port_ab_sel_o,
  output logic                      port_c_sel_o,
  output logic                      port_e_sel_o,
  output logic                      port_f_sel_o,
  output logic                      chip_select_zero_sel_o,
  output logic                      cs3_sel_o,
  output logic                      cs5_sel_o,
  output logic [4:0]                hi_cs_sel_o,
  output logic                      top_pin_unused_o,
  output logic                      emulation_chip_select_en_o,
  output logic                      module_chip_select_hold_o,
  output logic                      low_address_disable_bit_o,
  output logic                      low_address_oe_o,
  output logic                      synth_enable_o,
  output logic                      first_bus_cycle_o
);
  // positions of the pin levels inside the synchronised bundle
  localparam int DATA_W    = 16;
  localparam int CLK_POS   = DATA_W;
  localparam int BUS_ERROR_INPUT_POS  = DATA_W + 1;
  localparam int RESET_POS = DATA_W + 2;
  localparam int PINS_W    = DATA_W + 3;

  // widths of the upper select field and of the delay counter
  localparam int HICS_W = 5;
  localparam int CNT_W  = 4;

  // levels assumed while the block itself is held in reset
  localparam logic [DATA_W-1:0] DATA_IDLE = '1;
  localparam logic              CLK_IDLE  = 1'b1;
  localparam logic [CNT_W-1:0]  CNT_CLEAR = '0;

  // the delay must fit its counter and leave room for the idle start
  if (rmp_pkg::RMP_FIRST_CYCLE_CLKS < 1
      || rmp_pkg::RMP_FIRST_CYCLE_CLKS >= (1 << CNT_W)) begin : g_bad_delay
    $error("first bus cycle delay does not fit its counter");
  end

  // the select field must match its port and sit inside the data bus
  if (rmp_pkg::RMP_NUM_HICS != HICS_W) begin : g_bad_hics
    $error("upper select count does not match its output width");
  end
  if (rmp_pkg::RMP_D_CSLO + HICS_W > DATA_W) begin : g_bad_cslo
    $error("upper select option lines run past the data bus");
  end

  // everything the block remembers from one reset to the next
  typedef struct packed {
    logic              captured; // pin levels frozen
    rmp_pkg::rmp_bus_t bus;      // bus configuration
    logic [DATA_W-1:0] data;     // data line levels at capture
    logic              clk_sel;  // clock-mode level at capture
    logic              abd;      // low address disable bit
    logic [CNT_W-1:0]  wait_cnt; // cycles counted since capture
    logic              first;    // first bus cycle strobe
  } rmp_st_t;

  rmp_st_t           st_ff;
  rmp_st_t           nxt_st;
  logic [PINS_W-1:0] pins_sync;
  logic [DATA_W-1:0] sync_data;
  logic              sync_clk_sel;
  logic              sync_bus_error_input;
  logic              in_reset;
  logic [CNT_W-1:0]  cnt_inc;
  logic              cnt_done;
  logic              is8;
  logic              is16;
  logic              single;

  // pins cross into the core clock domain; the reset level goes in
  // inverted so that the all-ones reset of the stages reads as held
  rmp_sync2 #(
    .W (PINS_W)
  ) rmp_sync2_i (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .d_i        ({!sys_reset_n_i, bus_error_input_i,
                  clock_source_select_pin_i, data_pins_i}),
    .q_o        (pins_sync)
  );

  // named views of the synchronised bundle
  assign sync_data    = pins_sync[DATA_W-1:0];
  assign sync_clk_sel = pins_sync[CLK_POS];
  assign sync_bus_error_input    = pins_sync[BUS_ERROR_INPUT_POS];
  assign in_reset     = pins_sync[RESET_POS];

  // delay counter step and its end point; the end value is held, so
  // only one strobe follows each release
  assign cnt_inc  = st_ff.wait_cnt + CNT_W'(1);
  assign cnt_done = st_ff.wait_cnt == rmp_pkg::RMP_FIRST_CYCLE_CNT;

  // follow the pins while reset is held, freeze them at release
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.first = 1'b0;
    if (in_reset) begin
      // levels tracked every edge; the last one before release is kept
      nxt_st.captured = 1'b0;
      nxt_st.data     = sync_data;
      nxt_st.clk_sel  = sync_clk_sel;
      nxt_st.wait_cnt = CNT_CLEAR;
      if (!sync_bus_error_input) begin
        // no external bus at all: the low address pins start disabled
        nxt_st.bus = rmp_pkg::RMP_BUS_SINGLE;
        nxt_st.abd = 1'b1;
      end else if (sync_data[rmp_pkg::RMP_D_WIDTH]) begin
        nxt_st.bus = rmp_pkg::RMP_BUS_8BIT;
        nxt_st.abd = 1'b0;
      end else begin
        nxt_st.bus = rmp_pkg::RMP_BUS_16BIT;
        nxt_st.abd = 1'b0;
      end
    end else begin
      // the first edge after release keeps the last levels seen
      nxt_st.captured = 1'b1;
      if (low_address_disable_clr_i) begin
        nxt_st.abd = 1'b0;
      end
      // count to the first bus cycle once, then rest at the end value
      if (st_ff.captured && !cnt_done) begin
        nxt_st.wait_cnt = cnt_inc;
        nxt_st.first    = cnt_inc == rmp_pkg::RMP_FIRST_CYCLE_CNT;
      end
    end
  end

  // state register; the reset state has every data and clock level high
  // as the pull-ups read, the 16-bit bus code and no pin levels captured yet
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff.captured <= 1'b0;
      st_ff.bus      <= rmp_pkg::RMP_BUS_16BIT;
      st_ff.data     <= DATA_IDLE;
      st_ff.clk_sel  <= CLK_IDLE;
      st_ff.abd      <= 1'b0;
      st_ff.wait_cnt <= CNT_CLEAR;
      st_ff.first    <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // bus configuration views of the held state; the port, select and
  // emulation decodes below read only these and the frozen data levels
  assign single     = st_ff.bus == rmp_pkg::RMP_BUS_SINGLE;
  assign is8        = st_ff.bus == rmp_pkg::RMP_BUS_8BIT;
  assign is16       = st_ff.bus == rmp_pkg::RMP_BUS_16BIT;
  assign bus_mode_o = st_ff.bus;

  // data and address pins handed over to the I/O ports
  always_comb begin
    // port H takes the low byte whenever the bus is not 16 bits wide
    port_h_sel_o  = !is16;
    port_g_sel_o  = single;
    port_ab_sel_o = single;
    port_c_sel_o  = single;
  end

  // bus control and interrupt pins; single-chip always picks the ports
  always_comb begin
    port_e_sel_o = single || !st_ff.data[rmp_pkg::RMP_D_PORTE];
    port_f_sel_o = single || !st_ff.data[rmp_pkg::RMP_D_PORTF];
  end

  // boot select port size; only the 16-bit bus reads its option line
  assign boot_cs_16bit_o = is16 && st_ff.data[rmp_pkg::RMP_D_BOOT16];

  // chip selects 0, 3 and 5: fixed in 8-bit mode, optional in 16-bit
  always_comb begin
    chip_select_zero_sel_o = !is16 || st_ff.data[rmp_pkg::RMP_D_CS0];
    cs3_sel_o = is8 || (is16 && st_ff.data[rmp_pkg::RMP_D_CS0]);
    cs5_sel_o = is8 || (is16 && st_ff.data[rmp_pkg::RMP_D_CS0]);
  end

  // upper address/select pins: a low option line turns its own pin and
  // every lower one into address, so walk down from the top line
  always_comb begin
    logic hi_ok;
    hi_ok       = 1'b1;
    hi_cs_sel_o = '0;
    for (int i = HICS_W - 1; i >= 0; i--) begin
      hi_ok          = hi_ok && st_ff.data[rmp_pkg::RMP_D_CSLO + i];
      hi_cs_sel_o[i] = is8 || (is16 && hi_ok);
    end
  end

  // the top address/select pin has no job without an external bus
  assign top_pin_unused_o = single;

  // emulation support only on the 16-bit bus with lines 10 and 1 low
  always_comb begin
    emulation_chip_select_en_o = is16
      && !st_ff.data[rmp_pkg::RMP_D_EMUL]
      && !st_ff.data[rmp_pkg::RMP_D_WIDTH];
    // the module select hold only follows an enabled emulation select
    module_chip_select_hold_o = emulation_chip_select_en_o
      && !st_ff.data[rmp_pkg::RMP_D_MODCS];
  end

  // low address pins stay off until capture and while disabled
  always_comb begin
    low_address_disable_bit_o = st_ff.abd;
    low_address_oe_o          = st_ff.captured && !st_ff.abd;
  end

  // clock source and first bus cycle strobe
  assign synth_enable_o    = st_ff.clk_sel;
  assign first_bus_cycle_o = st_ff.first;
endmodule

// >>> verif/rmp_mode_drv.sv
`timescale 1ns/1ps
// mode-select conditioning: pulls pins low only while reset is held
module rmp_mode_drv (
  input  wire logic        rst_n_i,
  input  wire logic [15:0] mode_i,
  input  wire logic        clk_sel_i,
  output logic      [15:0] data_o,
  output logic             clk_pin_o
);
  // released lines float up to the pull-up level
  assign data_o = rst_n_i ? 16'hFFFF : mode_i;
  // actively driven, then reused as a port and flipped
  assign clk_pin_o = rst_n_i ? ~clk_sel_i : clk_sel_i;
endmodule

// >>> verif/rmp_reset_mode_chk.sv
`timescale 1ns/1ps
// pin map invariants and capture timing
module rmp_reset_mode_chk (
  input wire logic              core_clk_i,
  input wire logic              rstn_i,
  input wire logic              sys_reset_n_i,
  input wire rmp_pkg::rmp_bus_t bus_mode_o,
  input wire logic              boot_cs_16bit_o,
  input wire logic              port_h_sel_o,
  input wire logic              port_g_sel_o,
  input wire logic              port_ab_sel_o,
  input wire logic              port_e_sel_o,
  input wire logic              port_f_sel_o,
  input wire logic [4:0]        hi_cs_sel_o,
  input wire logic              emulation_chip_select_en_o,
  input wire logic              module_chip_select_hold_o,
  input wire logic              low_address_disable_bit_o,
  input wire logic              low_address_oe_o,
  input wire logic              first_bus_cycle_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire sc = bus_mode_o == rmp_pkg::RMP_BUS_SINGLE;
  wire nb = bus_mode_o == rmp_pkg::RMP_BUS_8BIT;
  // pin maps per bus mode
  AST_SINGLE_IO: assert property (sc |-> port_e_sel_o && port_f_sel_o
    && port_g_sel_o && port_ab_sel_o) else $error("single-chip port map");
  AST_NARROW_BUS: assert property (nb |-> port_h_sel_o
    && !port_g_sel_o && !port_ab_sel_o) else $error("8-bit port map");
  AST_NARROW_FIX: assert property (nb |-> !boot_cs_16bit_o
    && hi_cs_sel_o == 5'h1F) else $error("8-bit fixed selects");
  AST_NO_EMUL: assert property (emulation_chip_select_en_o |->
    bus_mode_o == rmp_pkg::RMP_BUS_16BIT) else $error("emulation select");
  AST_MOD_HOLD: assert property (module_chip_select_hold_o |->
    emulation_chip_select_en_o) else $error("module select hold");
  AST_LOW_ADDR: assert property (sc && low_address_disable_bit_o |->
    !low_address_oe_o) else $error("low address pins driven");
  // capture held, first bus cycle after release
  AST_HELD: assert property (sys_reset_n_i [*6] |->
    $stable({bus_mode_o, port_e_sel_o, port_f_sel_o}))
    else $error("configuration moved");
  AST_FIRST_CYCLE: assert property ($rose(sys_reset_n_i) ##1
    sys_reset_n_i [*8] |-> ##[2:6] first_bus_cycle_o)
    else $error("first bus cycle missing");
  cover property (sc ##1 !low_address_disable_bit_o);
  cover property (nb && port_e_sel_o);
  cover property (module_chip_select_hold_o);
endmodule

bind rmp_reset_mode rmp_reset_mode_chk rmp_reset_mode_chk_i (.*);

// >>> verif/rmp_reset_mode_bench.sv
`timescale 1ns/1ps
// sets mode pins under reset, releases it and checks the pin map
module rmp_reset_mode_bench;
  logic              core_clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic              sys_reset_n_i = 1'b0;
  logic              bus_error_input_i = 1'b1;
  logic              low_address_disable_clr_i = 1'b0;
  logic              csel = 1'b1;
  logic [15:0]       mode = 16'hFFFF;
  logic [15:0]       data_pins_i;
  logic              clock_source_select_pin_i;
  rmp_pkg::rmp_bus_t bus_mode_o;
  logic [4:0]        hi_cs_sel_o;
  logic              boot_cs_16bit_o, port_h_sel_o, port_g_sel_o;
  logic              port_ab_sel_o, port_c_sel_o, port_e_sel_o;
  logic              port_f_sel_o, chip_select_zero_sel_o, cs3_sel_o;
  logic              cs5_sel_o, top_pin_unused_o, synth_enable_o;
  logic              emulation_chip_select_en_o, module_chip_select_hold_o;
  logic              low_address_disable_bit_o, low_address_oe_o;
  logic              first_bus_cycle_o;
  int                compares = 0;
  int                miscompares = 0;
  int                cycles = 0;
  rmp_reset_mode rmp_reset_mode_i (.*);
  rmp_mode_drv rmp_mode_drv_i (.rst_n_i(sys_reset_n_i), .mode_i(mode),
    .clk_sel_i(csel), .data_o(data_pins_i),
    .clk_pin_o(clock_source_select_pin_i));
  // clock and hang guard
  initial forever #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one reset with pins d, bus error b, clock mode k
  task automatic run_case(input logic [15:0] d, input logic b, input logic k);
    logic       s, n, w;
    logic [4:0] hc;
    int         p;
    s = !b;
    n = b & d[1];
    w = b & !d[1];
    hc[4] = d[7];
    for (int i = 3; i >= 0; i--) hc[i] = hc[i+1] & d[3+i];
    p = 0;
    mode = d;
    bus_error_input_i = b;
    csel = k;
    sys_reset_n_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    sys_reset_n_i = 1'b1;
    repeat (16) begin
      @(negedge core_clk_i);
      p += int'(first_bus_cycle_o === 1'b1);
    end
    chk(16'(p), 16'h0001);
    chk(16'(bus_mode_o), {14'h0000, w, n});
    chk(16'({port_h_sel_o, port_g_sel_o, port_ab_sel_o}),
      16'({s | n, s, s}));
    chk(16'({port_c_sel_o, top_pin_unused_o}), 16'({s, s}));
    chk(16'(port_e_sel_o), 16'(s | !d[8]));
    chk(16'(port_f_sel_o), 16'(s | !d[9]));
    chk(16'(hi_cs_sel_o), 16'(n ? 5'h1F : (s ? 5'h00 : hc)));
    chk(16'({boot_cs_16bit_o, chip_select_zero_sel_o,
      cs3_sel_o, cs5_sel_o}),
      16'({w & d[0], s | n | (w & d[2]), {2{n | (w & d[2])}}}));
    chk(16'({emulation_chip_select_en_o, module_chip_select_hold_o}),
      16'({w & !d[10], w & !d[10] & !d[13]}));
    chk(16'(synth_enable_o), 16'(k));
    chk(16'({low_address_disable_bit_o, low_address_oe_o}),
      16'({s, !s}));
  endtask
  // corner configurations, address-pin clear, then random ones
  initial begin
    void'($urandom(57121));
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    run_case(16'h0000, 1'b0, 1'b1);
    low_address_disable_clr_i = 1'b1;
    @(negedge core_clk_i);
    low_address_disable_clr_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk(16'({low_address_disable_bit_o, low_address_oe_o}), 16'h0001);
    run_case(16'hFCFF, 1'b1, 1'b0);
    run_case(16'h0000, 1'b1, 1'b1);
    run_case(16'hFBFD, 1'b1, 1'b0);
    run_case(16'hFFFD, 1'b1, 1'b1);
    for (int i = 0; i < 40; i++) begin
      run_case(16'($urandom), 1'($urandom), 1'($urandom));
    end
    complete_run();
  end
endmodule
